// >>> rtl/eeprom_device.sv
// eeprom slave end: link logic on scl, self-timed write on ref_clk
`timescale 1ns/1ps
`include "eeprom_consts.svh"
module eeprom_device
#(
   parameter int BLOCKS       = `BLOCKS_DEFAULT,
   parameter int WRITE_CYCLES = `WRITE_CYCLES_DEFAULT
)
(
   // link
   eeprom_link_if.device link,
   // internal timing clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // pins
   input  wire logic       wp,
   input  wire logic [2:0] unused_address_pins,
   // status
   output logic            write_busy
);
   localparam int DEPTH = BLOCKS * 256;
   localparam int TW    = $clog2(WRITE_CYCLES + 1);
   initial
   begin
      if (!(BLOCKS == 2 || BLOCKS == 4) || WRITE_CYCLES < 1)
         $error("eeprom_device: BLOCKS must be 2 or 4 and WRITE_CYCLES at least 1");
   end
   // with 2 blocks the top block bit has no place in the address; with 4 it is kept
   function automatic logic [9:0] limit_addr(input logic [9:0] a);
      limit_addr = {(BLOCKS == 4) ? a[9] : 1'b0, a[8:0]};
   endfunction
   logic [7:0]                  mem [0:DEPTH-1];
   logic [7:0]                  page [0:`PAGE_BYTES-1];
   logic                        start_tgl, stop_tgl;
   eeprom_pkg::dev_state_t      state, next_state;
   logic                        reading, next_reading;
   logic [3:0]                  bitcnt, next_bitcnt;
   logic [6:0]                  shift;
   logic [7:0]                  tx, next_tx;
   logic                        ack_now, next_ack;
   logic [9:0]                  ptr, next_ptr;
   logic [15:0]                 page_mask, next_mask;
   logic                        page_we, start_seen, drive_low;
   logic                        pending, next_pending;
   logic [1:0]                  busy_sync, pend_sync, wp_sync;
   logic [2:0]                  stop_sync;
   eeprom_pkg::wr_state_t       wr_state, next_wr;
   logic [3:0]                  commit_idx;
   logic [TW-1:0]               timer;
   bus_condition_detect u_detect
   (
      .scl       (link.scl),
      .sda       (link.sda),
      .rst_b     (rst_b),
      .start_tgl (start_tgl),
      .stop_tgl  (stop_tgl)
   );
   // start settles under a high clock before the next rise: a synchroniser would eat bit 0
   wire       start_hit  = start_tgl != start_seen;
   wire [7:0] rx_byte    = {shift, link.sda};
   wire       byte_end   = bitcnt == `LAST_DATA_BIT;
   wire       ack_slot   = bitcnt == `ACK_BIT;
   wire       busy_scl   = busy_sync[1];
   // only the code decides selection, the address pins never enter here
   wire       ctrl_match = rx_byte[7:4] == `DEVICE_CODE;
   wire [9:0] read_addr  = limit_addr({rx_byte[2:1], ptr[7:0]});
   wire [9:0] ptr_inc    = limit_addr(ptr + 10'h001);
   wire       drive_val  = (ack_now && ack_slot) || (reading && !ack_slot && !tx[7]);
   wire       stop_evt   = stop_sync[2] ^ stop_sync[1];
   wire       commit_end = commit_idx == 4'hf;
   wire       timer_end  = timer == TW'(WRITE_CYCLES - 1);
   always_comb
   begin
      next_state   = state;
      next_reading = reading;
      next_bitcnt  = bitcnt + 4'h1;
      next_tx      = tx;
      next_ack     = ack_now;
      next_ptr     = ptr;
      next_mask    = page_mask;
      next_pending = pending;
      page_we      = 1'b0;
      if (start_hit)
      begin
         // a repeated start abandons a write whose pointer is already set
         next_state   = eeprom_pkg::DEV_CTRL;
         next_reading = 1'b0;
         next_bitcnt  = 4'h1;
         next_ack     = 1'b0;
         next_mask    = 16'h0000;
         next_pending = 1'b0;
      end
      else if (ack_slot)
      begin
         next_bitcnt = 4'h0;
         next_ack    = 1'b0;
         if (reading && !ack_now && link.sda)
         begin
            next_reading = 1'b0;
            next_state   = eeprom_pkg::DEV_IDLE;
         end
         else if (reading && !ack_now)
         begin
            next_tx  = mem[ptr];
            next_ptr = ptr_inc;
         end
      end
      else
      begin
         if (reading)
            next_tx = {tx[6:0], 1'b0};
         if (byte_end && !reading)
         begin
            unique case (state)
               eeprom_pkg::DEV_CTRL:
               begin
                  if (ctrl_match && !busy_scl)
                  begin
                     next_ack = 1'b1;
                     if (rx_byte[0])
                     begin
                        next_reading = 1'b1;
                        next_tx      = mem[read_addr];
                        next_ptr     = limit_addr(read_addr + 10'h001);
                     end
                     else
                     begin
                        next_state = eeprom_pkg::DEV_ADDR;
                        next_ptr   = limit_addr({rx_byte[2:1], ptr[7:0]});
                     end
                  end
                  else
                     next_state = eeprom_pkg::DEV_IDLE;
               end
               eeprom_pkg::DEV_ADDR:
               begin
                  next_ptr   = limit_addr({ptr[9:8], rx_byte});
                  next_ack   = 1'b1;
                  next_state = eeprom_pkg::DEV_WDATA;
               end
               eeprom_pkg::DEV_WDATA:
               begin
                  page_we               = 1'b1;
                  next_mask[ptr[3:0]]   = 1'b1;
                  next_ptr              = {ptr[9:4], ptr[3:0] + 4'h1};
                  next_ack              = 1'b1;
                  next_pending          = 1'b1;
               end
               eeprom_pkg::DEV_IDLE:
                  next_ack = 1'b0;
            endcase
         end
      end
   end
   always_ff @(posedge link.scl or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state      <= eeprom_pkg::DEV_IDLE;
         reading    <= 1'b0;
         bitcnt     <= 4'h0;
         shift      <= 7'h00;
         tx         <= 8'hff;
         ack_now    <= 1'b0;
         ptr        <= 10'h000;
         page_mask  <= 16'h0000;
         pending    <= 1'b0;
         start_seen <= 1'b0;
         busy_sync  <= 2'b00;
      end
      else
      begin
         state      <= next_state;
         reading    <= next_reading;
         bitcnt     <= next_bitcnt;
         shift      <= start_hit ? {6'h00, link.sda} : rx_byte[6:0];
         tx         <= next_tx;
         ack_now    <= next_ack;
         ptr        <= next_ptr;
         page_mask  <= next_mask;
         pending    <= next_pending;
         start_seen <= start_tgl;
         busy_sync  <= {busy_sync[0], write_busy};
      end
   end
   always_ff @(posedge link.scl)
   begin
      if (page_we)
         page[ptr[3:0]] <= rx_byte;
   end
   // the data line moves only on the falling clock
   always_ff @(negedge link.scl or negedge rst_b)
   begin
      if (!rst_b)
         drive_low <= 1'b0;
      else
         drive_low <= drive_val;
   end
   assign link.dev_sda_o    = 1'b0;
   assign link.dev_sda_oe_b = ~drive_low;
   // after a stop the link clock is still, so the write cycle is taken over here
   always_comb
   begin
      next_wr = wr_state;
      unique case (wr_state)
         eeprom_pkg::WR_IDLE:
            if (stop_evt && pend_sync[1] && !wp_sync[1])
               next_wr = eeprom_pkg::WR_COMMIT;
         eeprom_pkg::WR_COMMIT:
            if (commit_end)
               next_wr = eeprom_pkg::WR_WAIT;
         eeprom_pkg::WR_WAIT:
            if (timer_end)
               next_wr = eeprom_pkg::WR_IDLE;
         default:
            next_wr = eeprom_pkg::WR_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stop_sync  <= 3'b000;
         pend_sync  <= 2'b00;
         wp_sync    <= 2'b00;
         wr_state   <= eeprom_pkg::WR_IDLE;
         write_busy <= 1'b0;
         commit_idx <= 4'h0;
         timer      <= '0;
      end
      else
      begin
         stop_sync  <= {stop_sync[1:0], stop_tgl};
         pend_sync  <= {pend_sync[0], pending};
         wp_sync    <= {wp_sync[0], wp};
         wr_state   <= next_wr;
         write_busy <= next_wr != eeprom_pkg::WR_IDLE;
         commit_idx <= (wr_state == eeprom_pkg::WR_COMMIT) ? commit_idx + 4'h1 : 4'h0;
         timer      <= (wr_state == eeprom_pkg::WR_WAIT) ? timer + TW'(1) : '0;
      end
   end
   // page, mask and pointer hold still from stop to the next start, so no crossing
   always_ff @(posedge ref_clk)
   begin
      if (wr_state == eeprom_pkg::WR_COMMIT && page_mask[commit_idx])
         mem[limit_addr({ptr[9:4], commit_idx})] <= page[commit_idx];
   end
endmodule

// >>> common/eeprom_consts.svh
// constants for the serial eeprom command logic and its bus master
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH
`define DEVICE_CODE          4'ha
`define PAGE_BYTES           16
`define ACK_BIT              4'h8
`define LAST_DATA_BIT        4'h7
`define BLOCKS_DEFAULT       4
`define REF_CLK_MHZ          100
`define WRITE_TIME_MS        10
`define WRITE_CYCLES_DEFAULT (`WRITE_TIME_MS * 1000 * `REF_CLK_MHZ)
`define SCL_RATE_KHZ         100
`define SCL_QUARTER_DEFAULT  ((`REF_CLK_MHZ * 1000) / (`SCL_RATE_KHZ * 4))
`endif

// >>> common/eeprom_pkg.sv
// types shared by the serial eeprom ends
package eeprom_pkg;
   typedef enum logic [1:0] {
      DEV_IDLE  = 2'b00,
      DEV_CTRL  = 2'b01,
      DEV_ADDR  = 2'b10,
      DEV_WDATA = 2'b11
   } dev_state_t;
   typedef enum logic [1:0] {
      WR_IDLE   = 2'b00,
      WR_COMMIT = 2'b01,
      WR_WAIT   = 2'b10
   } wr_state_t;
   typedef enum logic [1:0] {
      CMD_START = 2'b00,
      CMD_STOP  = 2'b01,
      CMD_WRITE = 2'b10,
      CMD_READ  = 2'b11
   } cmd_kind_t;
   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_START = 2'b01,
      H_STOP  = 2'b10,
      H_BIT   = 2'b11
   } host_state_t;
endpackage

// >>> common/eeprom_link_if.sv
// two-wire link between the bus master and the eeprom
`timescale 1ns/1ps
interface eeprom_link_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe_b;
   logic dev_sda_o;
   logic dev_sda_oe_b;
   logic sda;
   // open-drain wire with pull-up: any enabled low driver wins
   assign sda = ((!host_sda_oe_b && !host_sda_o) || (!dev_sda_oe_b && !dev_sda_o)) ? 1'b0 : 1'b1;
   modport host (output scl, host_sda_o, host_sda_oe_b, input sda);
   modport device (input scl, sda, output dev_sda_o, dev_sda_oe_b);
endinterface

// >>> rtl/bus_condition_detect.sv
// start and stop detection on data-line edges while the clock is high
`timescale 1ns/1ps
module bus_condition_detect
(
   // link lines and reset
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic rst_b,
   // one toggle per condition seen
   output logic      start_tgl,
   output logic      stop_tgl
);
   // only a data edge under a high clock counts, ordinary bits never land here
   always_ff @(negedge sda or negedge rst_b)
   begin
      if (!rst_b)
         start_tgl <= 1'b0;
      else if (scl)
         start_tgl <= ~start_tgl;
   end

   always_ff @(posedge sda or negedge rst_b)
   begin
      if (!rst_b)
         stop_tgl <= 1'b0;
      else if (scl)
         stop_tgl <= ~stop_tgl;
   end
endmodule

// >>> rtl/eeprom_host.sv
// bus master end: makes scl by a divider and runs byte-level commands
`timescale 1ns/1ps
`include "eeprom_consts.svh"
module eeprom_host
#(
   parameter int QUARTER = `SCL_QUARTER_DEFAULT
)
(
   // link
   eeprom_link_if.host          link,
   // clock and reset
   input  wire logic            ref_clk,
   input  wire logic            rst_b,
   // command
   input  wire logic            cmd_valid,
   input  eeprom_pkg::cmd_kind_t cmd_kind,
   input  wire logic [7:0]      cmd_data,
   input  wire logic            cmd_ack,
   output logic                 cmd_ready,
   // response
   output logic                 rsp_valid,
   output logic [7:0]           rsp_data,
   output logic                 rsp_ack
);
   localparam int QW = $clog2(QUARTER + 1);

   initial
   begin
      if (QUARTER < 4)
         $error("eeprom_host: QUARTER must be at least 4 for the input synchroniser");
   end

   eeprom_pkg::host_state_t state;
   eeprom_pkg::cmd_kind_t   kind;
   logic [QW-1:0]           qcnt;
   logic [1:0]              phase;
   logic [3:0]              bit_idx;
   logic [7:0]              sh;
   logic                    ack_req;
   logic                    scl_q;
   logic                    sda_low;
   logic [1:0]              sda_sync;

   wire tick     = qcnt == QW'(QUARTER - 1);
   wire is_write = kind == eeprom_pkg::CMD_WRITE;
   wire data_bit = bit_idx != `ACK_BIT;
   // in the ack slot a write releases, a read acks to ask for more
   wire bit_low  = data_bit ? (is_write && !sh[7]) : (!is_write && ack_req);
   wire sda_in   = sda_sync[1];

   assign cmd_ready          = state == eeprom_pkg::H_IDLE;
   assign link.scl           = scl_q;
   assign link.host_sda_o    = 1'b0;
   assign link.host_sda_oe_b = ~sda_low;

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         sda_sync <= 2'b11;
      else
         sda_sync <= {sda_sync[0], link.sda};
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state     <= eeprom_pkg::H_IDLE;
         kind      <= eeprom_pkg::CMD_START;
         qcnt      <= '0;
         phase     <= 2'b00;
         bit_idx   <= 4'h0;
         sh        <= 8'h00;
         ack_req   <= 1'b0;
         scl_q     <= 1'b1;
         sda_low   <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data  <= 8'h00;
         rsp_ack   <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         qcnt      <= (state == eeprom_pkg::H_IDLE || tick) ? '0 : qcnt + QW'(1);
         if (state == eeprom_pkg::H_IDLE)
         begin
            if (cmd_valid)
            begin
               kind    <= cmd_kind;
               sh      <= cmd_data;
               ack_req <= cmd_ack;
               bit_idx <= 4'h0;
               phase   <= 2'b00;
               unique case (cmd_kind)
                  eeprom_pkg::CMD_START: state <= eeprom_pkg::H_START;
                  eeprom_pkg::CMD_STOP:  state <= eeprom_pkg::H_STOP;
                  eeprom_pkg::CMD_WRITE: state <= eeprom_pkg::H_BIT;
                  eeprom_pkg::CMD_READ:  state <= eeprom_pkg::H_BIT;
               endcase
            end
         end
         else if (tick)
         begin
            phase <= phase + 2'b01;
            unique case (state)
               // data edges under a high clock only for start and stop
               eeprom_pkg::H_START:
                  unique case (phase)
                     2'b00: sda_low <= 1'b0;
                     2'b01: scl_q   <= 1'b1;
                     2'b10: sda_low <= 1'b1;
                     2'b11:
                     begin
                        scl_q <= 1'b0;
                        state <= eeprom_pkg::H_IDLE;
                     end
                  endcase
               eeprom_pkg::H_STOP:
                  unique case (phase)
                     2'b00: sda_low <= 1'b1;
                     2'b01: scl_q   <= 1'b1;
                     2'b10: sda_low <= 1'b0;
                     2'b11: state   <= eeprom_pkg::H_IDLE;
                  endcase
               eeprom_pkg::H_BIT:
                  unique case (phase)
                     2'b00: sda_low <= bit_low;
                     2'b01: scl_q   <= 1'b1;
                     2'b10:
                        if (data_bit)
                           rsp_data <= {rsp_data[6:0], sda_in};
                        else
                           rsp_ack <= !sda_in;
                     2'b11:
                     begin
                        scl_q <= 1'b0;
                        if (data_bit)
                        begin
                           sh      <= {sh[6:0], 1'b0};
                           bit_idx <= bit_idx + 4'h1;
                        end
                        else
                        begin
                           // a read ack is let go at the next bit, never under a falling clock
                           rsp_valid <= 1'b1;
                           state     <= eeprom_pkg::H_IDLE;
                        end
                     end
                  endcase
               default:
                  state <= eeprom_pkg::H_IDLE;
            endcase
         end
      end
   end
endmodule

// >>> bench/eeprom_link_properties.sv
// assertions on the two-wire link and the device write timer
`timescale 1ns/1ps
`include "eeprom_consts.svh"
module eeprom_link_properties
#(
   parameter int WRITE_CYCLES = 400
)
(
   // link lines
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe_b,
   // device timing
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic write_busy
);
   logic        scl_q;
   logic        sda_q;
   logic [4:0]  rises;
   logic [7:0]  since_stop;
   logic [15:0] busy_len;
   logic [7:0]  ctrl_byte;
   wire         start_c = scl && scl_q && sda_q && !sda;
   wire         stop_c = scl && scl_q && !sda_q && sda;
   // scl rises since the last start, saturating so long reads never wrap into 1..8
   wire [4:0]   next_rises = start_c ? 5'h0 : rises + {4'h0, scl && !scl_q && rises != 5'h1f};
   wire [7:0]   next_since = stop_c ? 8'h0 : since_stop + {7'h0, since_stop != 8'hff};
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
         rises <= 5'h0;
         since_stop <= 8'hff;
         busy_len <= 16'h0;
         ctrl_byte <= 8'h00;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
         rises <= next_rises;
         since_stop <= next_since;
         busy_len <= write_busy ? busy_len + 16'h1 : 16'h0;
         ctrl_byte <= (scl && !scl_q && rises < 5'h8) ? {ctrl_byte[6:0], sda} : ctrl_byte;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   property p_dev_scl_low;
      $changed(dev_sda_oe_b) |-> !scl;
   endproperty
   a_dev_scl_low: assert property (p_dev_scl_low)
      else $error("device changed sda while scl high");
   property p_dev_released_at_cond;
      scl && $changed(sda) |-> dev_sda_oe_b && $past(dev_sda_oe_b);
   endproperty
   a_dev_released_at_cond: assert property (p_dev_released_at_cond)
      else $error("device held sda at a start or stop");
   // first high cycle of each pulse is skipped: the count lands one cycle late
   property p_ctrl_quiet;
      scl && scl_q && rises >= 5'h1 && rises <= 5'h8 |-> dev_sda_oe_b;
   endproperty
   a_ctrl_quiet: assert property (p_ctrl_quiet)
      else $error("device drove sda during the control byte");
   // an ack on the ninth clock only answers a control byte with the device code
   property p_ack_low;
      scl && scl_q && rises == 5'h9 && !dev_sda_oe_b |-> ctrl_byte[7:4] == `DEVICE_CODE;
   endproperty
   a_ack_low: assert property (p_ack_low)
      else $error("device acked a control byte with a foreign code");
   property p_busy_quiet;
      write_busy |-> dev_sda_oe_b;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("device drove sda while busy");
   property p_busy_from_stop;
      $rose(write_busy) |-> since_stop <= 8'h8;
   endproperty
   a_busy_from_stop: assert property (p_busy_from_stop)
      else $error("write cycle began without a stop");
   property p_busy_len;
      $fell(write_busy) |-> busy_len >= WRITE_CYCLES && busy_len <= WRITE_CYCLES + 24;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("write cycle length off");
   property p_stop_free;
      stop_c |=> scl && sda;
   endproperty
   a_stop_free: assert property (p_stop_free)
      else $error("bus not free after stop");
   c_busy: cover property ($rose(write_busy));
   c_ctrl_ack: cover property (scl && scl_q && rises == 5'h9 && !dev_sda_oe_b);
   c_stop: cover property (stop_c);
endmodule

// >>> bench/test_serial_eeprom_i2c_command_logic.sv
// testbench joining the bus master and the eeprom across the link
`timescale 1ns/1ps
`include "eeprom_consts.svh"
module test_serial_eeprom_i2c_command_logic;
   localparam int WCYC = 400;
   logic                  ref_clk;
   logic                  rst_b;
   logic                  cmd_valid;
   eeprom_pkg::cmd_kind_t cmd_kind;
   logic [7:0]            cmd_data;
   logic                  cmd_ack;
   logic                  cmd_ready;
   logic                  rsp_valid;
   logic [7:0]            rsp_data;
   logic                  rsp_ack;
   logic                  wp;
   logic [2:0]            unused_address_pins;
   logic                  write_busy;
   logic [7:0]            got;
   logic                  gack;
   int                    fails;
   int                    checks;
   eeprom_link_if eeprom_link_if_inst ();
   eeprom_host #(.QUARTER(4)) eeprom_host_inst (.link(eeprom_link_if_inst),
      .ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
      .cmd_data(cmd_data), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
   eeprom_device #(.BLOCKS(4), .WRITE_CYCLES(WCYC)) eeprom_device_inst (
      .link(eeprom_link_if_inst), .ref_clk(ref_clk), .rst_b(rst_b), .wp(wp),
      .unused_address_pins(unused_address_pins), .write_busy(write_busy));
   eeprom_link_properties #(.WRITE_CYCLES(WCYC)) eeprom_link_properties_inst (
      .scl(eeprom_link_if_inst.scl), .sda(eeprom_link_if_inst.sda),
      .dev_sda_oe_b(eeprom_link_if_inst.dev_sda_oe_b), .ref_clk(ref_clk),
      .rst_b(rst_b), .write_busy(write_busy));
   always #5 ref_clk = ~ref_clk;
   task automatic stop_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checks++;
      if (s !== e)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic s);
      checks++;
      if (s !== e)
      begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // one command: held until taken, then wait for the host to return idle
   task automatic cmd(input eeprom_pkg::cmd_kind_t k, input logic [7:0] d, input logic a);
      @(posedge ref_clk);
      #1;
      cmd_valid = 1'h1;
      cmd_kind = k;
      cmd_data = d;
      cmd_ack = a;
      @(posedge ref_clk);
      while (cmd_ready !== 1'h1)
         @(posedge ref_clk);
      #1;
      cmd_valid = 1'h0;
      do
      begin
         @(posedge ref_clk);
         #1;
         if (rsp_valid === 1'h1)
         begin
            got = rsp_data;
            gack = rsp_ack;
         end
      end
      while (cmd_ready !== 1'h1);
   endtask
   task automatic st();
      cmd(eeprom_pkg::CMD_START, 8'h00, 1'h0);
   endtask
   task automatic sp();
      cmd(eeprom_pkg::CMD_STOP, 8'h00, 1'h0);
   endtask
   task automatic wr(input logic [7:0] d, input logic e);
      cmd(eeprom_pkg::CMD_WRITE, d, 1'h0);
      chk1("ack", e, gack);
   endtask
   task automatic rd(input logic a, input logic [7:0] e);
      cmd(eeprom_pkg::CMD_READ, 8'h00, a);
      chk("read data", e, got);
   endtask
   task automatic poll(input logic e);
      st();
      wr({`DEVICE_CODE, 3'h0, 1'h0}, e);
      sp();
   endtask
   task automatic wr_frame(input logic [2:0] b, input logic [7:0] w, input int n,
                           input logic [7:0] base);
      st();
      wr({`DEVICE_CODE, b, 1'h0}, 1'h1);
      wr(w, 1'h1);
      for (int i = 0; i < n; i++)
         wr(base + i[7:0], 1'h1);
      sp();
   endtask
   // polls once while busy, then again once the timer has run out
   task automatic settle(input logic busy);
      int n;
      n = 0;
      while (n < 12 && write_busy !== 1'h1)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk1("write_busy", busy, write_busy);
      if (busy)
      begin
         poll(1'h0);
         while (write_busy !== 1'h0)
            @(posedge ref_clk);
      end
      poll(1'h1);
   endtask
   task automatic rd_frame(input logic [2:0] b, input logic [7:0] w);
      st();
      wr({`DEVICE_CODE, b, 1'h0}, 1'h1);
      wr(w, 1'h1);
      st();
      wr({`DEVICE_CODE, b, 1'h1}, 1'h1);
   endtask
   initial
   begin
      #500000;
      fails++;
      stop_test();
   end
   initial
   begin
      ref_clk = 1'h0;
      rst_b = 1'h0;
      cmd_valid = 1'h0;
      cmd_kind = eeprom_pkg::CMD_START;
      cmd_data = 8'h00;
      cmd_ack = 1'h0;
      wp = 1'h0;
      unused_address_pins = 3'h0;
      fails = 0;
      checks = 0;
      repeat (12) @(posedge ref_clk);
      #1;
      rst_b = 1'h1;
      // 18 bytes from word 3e: the last two land on 3e and 3f again
      wr_frame(3'h2, 8'h3e, 18, 8'h80);
      settle(1'h1);
      wr_frame(3'h1, 8'h3f, 1, 8'h5a);
      settle(1'h1);
      unused_address_pins = 3'h5;
      rd_frame(3'h2, 8'h3b);
      rd(1'h1, 8'h8d);
      rd(1'h1, 8'h8e);
      rd(1'h1, 8'h8f);
      rd(1'h0, 8'h90);
      sp();
      st();
      wr({`DEVICE_CODE, 3'h6, 1'h1}, 1'h1);
      rd(1'h0, 8'h91);
      sp();
      rd_frame(3'h1, 8'h3f);
      rd(1'h0, 8'h5a);
      sp();
      st();
      wr({4'h5, 3'h0, 1'h0}, 1'h0);
      st();
      wr({4'hb, 3'h0, 1'h0}, 1'h0);
      sp();
      wp = 1'h1;
      repeat (4) @(posedge ref_clk);
      wr_frame(3'h1, 8'h3f, 1, 8'h33);
      settle(1'h0);
      rd_frame(3'h1, 8'h3f);
      rd(1'h0, 8'h5a);
      sp();
      wp = 1'h0;
      stop_test();
   end
endmodule
